// file: rtl/pcr_pkg.sv
// package: constants and carrier types of the power-up and reset block
package pcr_pkg;

   // ******************************
   // bus
   // ******************************
   localparam int ADDR_W = 8;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } pcr_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pcr_axi_rsp_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ******************************
   // register map
   // ******************************
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IST    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IMASK  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TRIM   = 8'h10;

   // control register fields
   localparam int CTRL_SOFT_RST = 0;
   localparam int CTRL_LOOK     = 1;
   localparam int CTRL_SNK_SW   = 2;
   localparam int CTRL_SRC_SW   = 3;
   localparam int CTRL_DBG_EN   = 4;
   localparam int CTRL_ORIENT   = 5;
   localparam int CTRL_GIO1     = 6;
   localparam int CTRL_GIO2     = 7;
   localparam logic [7:0] CTRL_RESET  = 8'h10;

   // status register fields
   localparam int STAT_VDD    = 0;
   localparam int STAT_VBUS   = 1;
   localparam int STAT_DEAD   = 2;
   localparam int STAT_RUN    = 3;
   localparam int STAT_TOGGLE = 4;
   localparam int STAT_CC_RP  = 5;
   localparam int STAT_PAIR   = 6;
   localparam int STAT_ADDR   = 8;

   // interrupt status and mask fields
   localparam int IRQ_W         = 4;
   localparam int IRQ_PORT_PWR  = 0;
   localparam int IRQ_INIT      = 1;
   localparam int IRQ_ATTACH    = 2;
   localparam int IRQ_DEBUG     = 3;
   localparam logic [IRQ_W-1:0] IMASK_RESET = 4'hF;

   // serial slave address: fixed upper bits, then pairing, then strap
   localparam logic [4:0] I2C_ADDR_BASE = 5'h14;

   // ******************************
   // timing
   // ******************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int TOGGLE_PERIOD_NS = 20000;
   localparam int TOGGLE_CYC       = TOGGLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TOG_W            = 11;

   // ******************************
   // power sequence and pin carriers
   // ******************************
   typedef enum logic [2:0] {
      PWR_OFF    = 3'h0,
      PWR_LOAD   = 3'h1,
      PWR_FUSE   = 3'h3,
      PWR_SAMPLE = 3'h2,
      PWR_RUN    = 3'h6
   } pcr_pwr_t;

   typedef struct packed {
      logic cc1_rp_en;
      logic cc2_rp_en;
      logic cc1_rd_en;
      logic cc2_rd_en;
   } pcr_cc_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } pcr_pin_drv_t;

endpackage : pcr_pkg

// file: rtl/pcr_sync.sv
// three-stage synchroniser with agreement filter for outside levels
`timescale 1ns/100ps
module pcr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import pcr_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pcr_sync_state_t;

   pcr_sync_state_t s_q;
   pcr_sync_state_t s_d;

   if (W < 1) begin : g_chk
      $error("pcr_sync: width must be at least one");
   end

   always_comb begin
      s_d    = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < W; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.q[i] = s_q.s3[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.q;

endmodule : pcr_sync

// file: rtl/pcr_top.sv
// power-up, reset and dead-battery start-up logic of the port controller
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module pcr_top #(
   parameter int FUSE_WORDS = 4
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // register bus
   input  wire pcr_pkg::pcr_axi_req_t axi_req,
   output pcr_pkg::pcr_axi_rsp_t      axi_rsp,
   // supply levels
   input  wire logic                  main_supply_good_level,
   input  wire logic                  vbus_present,
   // trim fuses
   output logic [1:0]                 fuse_addr,
   input  wire logic [7:0]            fuse_data,
   // detection results
   input  wire logic                  src_attached,
   input  wire logic                  debug_acc_detected,
   // serial clock pins, for pairing detection
   input  wire logic                  i2c_scl1_pin,
   input  wire logic                  i2c_scl2_pin,
   output logic [6:0]                 i2c_slave_addr,
   // configuration channel presentation
   output pcr_pkg::pcr_cc_t           cc_pres,
   // pins
   input  wire logic                  orientation_addr_select_pin_i,
   output pcr_pkg::pcr_pin_drv_t      orientation_addr_select_pin,
   output pcr_pkg::pcr_pin_drv_t      int_n_pin,
   output pcr_pkg::pcr_pin_drv_t      debug_acc_detect_out,
   output logic                       sink_switch_en,
   output logic                       source_switch_en,
   output logic                       general_io_one,
   output logic                       general_io_two
);
   import pcr_pkg::*;

   typedef struct packed {
      pcr_pwr_t          pwr;
      logic [1:0]        fidx;
      logic [3:0][7:0]   trim;
      logic [7:0]        ctrl;
      logic [IRQ_W-1:0]  ist;
      logic [IRQ_W-1:0]  imask;
      logic              addr_sel;
      logic              pair_known;
      logic              pair2;
      logic              toggling;
      logic              cc_rp;
      logic [TOG_W-1:0]  tog_cnt;
      logic              attach_q;
      logic              debug_q;
      logic              scl1_q;
      logic              scl2_q;
      logic              sink;
      logic              source;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } pcr_state_t;

   localparam pcr_state_t STATE_RESET = '{
      pwr: PWR_OFF, ctrl: CTRL_RESET, imask: IMASK_RESET, default: '0};

   localparam logic [TOG_W-1:0] TOG_RELOAD = TOG_W'(TOGGLE_CYC - 1);

   if (FUSE_WORDS < 1 || FUSE_WORDS > 4) begin : g_chk
      $error("pcr_top: FUSE_WORDS must lie in 1..4");
   end

   pcr_state_t s_q;
   pcr_state_t s_d;
   logic [4:0] pin_s;
   logic       vdd_s;
   logic       vbus_s;
   logic       addr_pin_s;
   logic       scl1_s;
   logic       scl2_s;
   logic       supply;
   logic       dead;
   logic       run;
   logic       wr_go;
   logic [7:0] wb;
   logic [IRQ_W-1:0] ev;

   // ******************************
   // functions
   // ******************************
   function automatic logic pcr_mapped(input logic [ADDR_W-1:0] a);
      return a == OFS_CTRL || a == OFS_STATUS || a == OFS_IST ||
             a == OFS_IMASK || a == OFS_TRIM;
   endfunction : pcr_mapped

   function automatic logic [31:0] pcr_read(input pcr_state_t s,
                                            input logic [ADDR_W-1:0] a,
                                            input logic [31:0] stat);
      logic [31:0] r;
      r = '0;
      case (a)
         OFS_CTRL:   r[7:0]       = s.ctrl;
         OFS_STATUS: r            = stat;
         OFS_IST:    r[IRQ_W-1:0] = s.ist;
         OFS_IMASK:  r[IRQ_W-1:0] = s.imask;
         OFS_TRIM:   r            = s.trim;
         default:    r            = '0;
      endcase
      return r;
   endfunction : pcr_read

   // ******************************
   // pin synchronisers
   // ******************************
   pcr_sync #(.W(5)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({main_supply_good_level, vbus_present,
                 orientation_addr_select_pin_i, i2c_scl1_pin,
                 i2c_scl2_pin}),
      .q       (pin_s)
   );

   assign {vdd_s, vbus_s, addr_pin_s, scl1_s, scl2_s} = pin_s;
   assign supply = vdd_s | vbus_s;
   assign dead   = vbus_s & ~vdd_s;
   assign run    = (s_q.pwr == PWR_RUN);
   assign wr_go  = s_q.aw_held & s_q.w_held;
   assign wb     = s_q.w_strb[0] ? s_q.w_data[7:0] : 8'h00;

   // ******************************
   // next state
   // ******************************
   always_comb begin
      logic [31:0] stat;
      stat = '0;
      s_d  = s_q;
      ev   = '0;
      stat[STAT_VDD]    = vdd_s;
      stat[STAT_VBUS]   = vbus_s;
      stat[STAT_DEAD]   = dead;
      stat[STAT_RUN]    = run;
      stat[STAT_TOGGLE] = s_q.toggling;
      stat[STAT_CC_RP]  = s_q.cc_rp;
      stat[STAT_PAIR]   = s_q.pair_known;
      stat[STAT_ADDR +: 7] = i2c_slave_addr;

      // bus channels
      if (axi_req.awvalid && axi_rsp.awready) begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         s_d.w_held = 1'b1;
         s_d.w_data = axi_req.wdata;
         s_d.w_strb = axi_req.wstrb;
      end
      if (s_q.bvalid && axi_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = pcr_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.rvalid && axi_req.rready) begin
         s_d.rvalid = 1'b0;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = pcr_read(s_q, axi_req.araddr, stat);
         s_d.rresp  = pcr_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // register writes
      if (wr_go && s_q.aw_addr == OFS_CTRL && s_q.w_strb[0]) begin
         s_d.ctrl = s_q.w_data[7:0];
         if (s_q.w_data[CTRL_SOFT_RST] && run) begin
            s_d.pwr = PWR_LOAD;
         end
      end
      if (wr_go && s_q.aw_addr == OFS_IST) begin
         s_d.ist = s_q.ist & ~wb[IRQ_W-1:0];
      end
      if (wr_go && s_q.aw_addr == OFS_IMASK) begin
         s_d.imask = s_q.w_strb[0] ? s_q.w_data[IRQ_W-1:0] : s_q.imask;
      end

      // power sequence
      case (s_q.pwr)
         PWR_OFF: begin
            if (supply) begin
               s_d.pwr = PWR_LOAD;
            end
         end
         PWR_LOAD: begin
            s_d.ctrl       = CTRL_RESET;
            s_d.ist        = '0;
            s_d.imask      = IMASK_RESET;
            s_d.trim       = '0;
            s_d.fidx       = '0;
            s_d.addr_sel   = 1'b0;
            s_d.pair_known = 1'b0;
            s_d.pair2      = 1'b0;
            s_d.pwr        = PWR_FUSE;
         end
         PWR_FUSE: begin
            s_d.trim[s_q.fidx] = fuse_data;
            s_d.fidx = s_q.fidx + 2'd1;
            if (s_q.fidx == 2'(FUSE_WORDS - 1)) begin
               s_d.pwr = PWR_SAMPLE;
            end
         end
         PWR_SAMPLE: begin
            s_d.addr_sel = addr_pin_s;
            s_d.pwr      = PWR_RUN;
            ev[IRQ_PORT_PWR] = 1'b1;
            ev[IRQ_INIT]     = 1'b1;
         end
         PWR_RUN: begin
            if (!s_q.pair_known && s_q.scl1_q && !scl1_s) begin
               s_d.pair_known = 1'b1;
               s_d.pair2      = 1'b0;
            end else if (!s_q.pair_known && s_q.scl2_q && !scl2_s) begin
               s_d.pair_known = 1'b1;
               s_d.pair2      = 1'b1;
            end
            ev[IRQ_ATTACH] = src_attached != s_q.attach_q;
            ev[IRQ_DEBUG]  = debug_acc_detected != s_q.debug_q;
         end
         default: s_d.pwr = PWR_OFF;
      endcase
      if (!supply) begin
         s_d.pwr = PWR_OFF;
      end
      s_d.ist      = s_d.ist | ev;
      s_d.attach_q = src_attached;
      s_d.debug_q  = debug_acc_detected;
      s_d.scl1_q   = scl1_s;
      s_d.scl2_q   = scl2_s;

      // role toggling
      if (!run || !vdd_s || !s_q.ctrl[CTRL_LOOK]) begin
         s_d.toggling = 1'b0;
         s_d.cc_rp    = 1'b0;
         s_d.tog_cnt  = TOG_RELOAD;
      end else if (src_attached) begin
         s_d.toggling = 1'b0;
      end else begin
         s_d.toggling = 1'b1;
         if (s_q.tog_cnt == '0) begin
            s_d.cc_rp   = ~s_q.cc_rp;
            s_d.tog_cnt = TOG_RELOAD;
         end else begin
            s_d.tog_cnt = s_q.tog_cnt - TOG_W'(1);
         end
      end

      // load switches
      s_d.sink   = dead ? src_attached
                        : (run && s_q.ctrl[CTRL_SNK_SW]);
      s_d.source = run && vdd_s && s_q.ctrl[CTRL_SRC_SW];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign axi_rsp.awready = !s_q.aw_held && !s_q.bvalid;
   assign axi_rsp.wready  = !s_q.w_held && !s_q.bvalid;
   assign axi_rsp.bvalid  = s_q.bvalid;
   assign axi_rsp.bresp   = s_q.bresp;
   assign axi_rsp.arready = !s_q.rvalid;
   assign axi_rsp.rvalid  = s_q.rvalid;
   assign axi_rsp.rdata   = s_q.rdata;
   assign axi_rsp.rresp   = s_q.rresp;

   assign fuse_addr      = s_q.fidx;
   assign i2c_slave_addr = {I2C_ADDR_BASE, s_q.pair2, s_q.addr_sel};

   assign cc_pres.cc1_rp_en = s_q.cc_rp;
   assign cc_pres.cc2_rp_en = s_q.cc_rp;
   assign cc_pres.cc1_rd_en = !s_q.cc_rp;
   assign cc_pres.cc2_rd_en = !s_q.cc_rp;

   assign orientation_addr_select_pin.out  = s_q.ctrl[CTRL_ORIENT];
   assign orientation_addr_select_pin.oe_n = !run;
   assign int_n_pin.out  = 1'b0;
   assign int_n_pin.oe_n = !(|(s_q.ist & s_q.imask));
   assign debug_acc_detect_out.out  = 1'b0;
   assign debug_acc_detect_out.oe_n =
      !(run && s_q.debug_q && s_q.ctrl[CTRL_DBG_EN]);
   assign sink_switch_en   = s_q.sink;
   assign source_switch_en = s_q.source;
   assign general_io_one   = s_q.ctrl[CTRL_GIO1];
   assign general_io_two   = s_q.ctrl[CTRL_GIO2];

   // ******************************
   // assertions
   // ******************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_power_up_load: assert property (
      (s_q.pwr == PWR_OFF && supply) |=> s_q.pwr == PWR_LOAD ##1
      s_q.pwr == PWR_FUSE) else $error("power-up did not start load");
   a_soft_reset: assert property (
      (run && supply && wr_go && s_q.aw_addr == OFS_CTRL &&
       s_q.w_strb[0] && s_q.w_data[CTRL_SOFT_RST])
      |=> s_q.pwr == PWR_LOAD ##1 s_q.ctrl == CTRL_RESET)
      else $error("soft reset did not reload defaults");
   a_off_rd_pres: assert property (
      s_q.pwr == PWR_OFF |=> cc_pres.cc1_rd_en && cc_pres.cc2_rd_en &&
      !cc_pres.cc1_rp_en) else $error("unpowered without pull-downs");
   a_dead_rd_pres: assert property (
      $past(dead) && dead |-> cc_pres.cc1_rd_en && cc_pres.cc2_rd_en)
      else $error("dead battery without pull-downs");
   a_toggle_flip: assert property (
      (s_q.toggling && s_q.tog_cnt == '0 && run && vdd_s && supply &&
       s_q.ctrl[CTRL_LOOK] && !src_attached)
      |=> s_q.cc_rp != $past(s_q.cc_rp))
      else $error("toggle did not flip presentation");
   a_dead_sink_on: assert property (
      (dead && src_attached) |=> sink_switch_en)
      else $error("dead battery sink path not enabled");
   a_addr_pin_dir: assert property (
      s_q.pwr == PWR_SAMPLE |-> orientation_addr_select_pin.oe_n ##1
      (!supply || (s_q.addr_sel == $past(addr_pin_s) &&
       !orientation_addr_select_pin.oe_n)))
      else $error("address strap not sampled before driving");
   a_addr_value: assert property (
      i2c_slave_addr[1:0] == {s_q.pair2, s_q.addr_sel} &&
      i2c_slave_addr[6:2] == I2C_ADDR_BASE)
      else $error("slave address wrong");
   a_int_pin: assert property (
      (s_q.ist[IRQ_INIT] && s_q.imask[IRQ_INIT]) |-> !int_n_pin.oe_n &&
      !int_n_pin.out) else $error("interrupt pin not pulled low");
   a_sink_off: assert property (
      (!dead && !s_q.ctrl[CTRL_SNK_SW]) |=> !sink_switch_en)
      else $error("sink switch on without command");
   a_source_gate: assert property (
      !vdd_s |=> !source_switch_en)
      else $error("source switch on without main supply");
   a_debug_pin: assert property (
      !debug_acc_detect_out.oe_n |-> $past(debug_acc_detected) && run)
      else $error("debug output without detection");
   a_init_irq: assert property (
      (s_q.pwr == PWR_SAMPLE && supply) |=>
      s_q.ist[IRQ_PORT_PWR] && s_q.ist[IRQ_INIT] && !int_n_pin.oe_n)
      else $error("no interrupt after initialisation");
   a_soft_clear: assert property (
      s_q.pwr == PWR_LOAD |=> !s_q.ctrl[CTRL_SOFT_RST])
      else $error("soft reset bit did not clear");

endmodule : pcr_top

// file: verif/pcr_mgr_model.sv
// port manager model: drives the serial clock lines of its chosen pairing
`timescale 1ns/100ps
module pcr_mgr_model (
   // frame control from the bench
   input  wire logic frame,
   input  wire logic use_two,
   // serial clock lines, pulled up when idle
   output logic      scl1,
   output logic      scl2
);
   logic line_lvl;

   // link clock of 125 ns, runs only inside a frame
   initial begin
      line_lvl = 1'h1;
      #3;
      forever begin
         #62.5;
         line_lvl = frame ? ~line_lvl : 1'h1;
      end
   end

   // the unused pairing stays at its pull-up level
   assign scl1 = (frame && !use_two) ? line_lvl : 1'h1;
   assign scl2 = (frame && use_two) ? line_lvl : 1'h1;
endmodule : pcr_mgr_model

// file: verif/tb.sv
// testbench of the power-up, reset and dead-battery block
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("ERROR %0t mismatch got %h exp %h", $time, (a), (e)); end end
module tb;
   import pcr_pkg::*;
   logic          aclk, aresetn, vdd, vbus, src_att, dbg_det;
   logic          frame, use_two, strap, scl1, scl2;
   logic          sink_en, src_en, gio1, gio2;
   logic [1:0]    fuse_addr, r;
   logic [6:0]    slave_addr;
   logic [31:0]   d;
   pcr_axi_req_t  req;
   pcr_axi_rsp_t  rsp;
   pcr_cc_t       cc;
   pcr_pin_drv_t  orient, int_n, dbg_out;
   int            err_total = 0, checks_done = 0, cyc = 0, n;

   pcr_top i_pcr_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .main_supply_good_level(vdd), .vbus_present(vbus),
      .fuse_addr(fuse_addr), .fuse_data(8'hA0 + {6'h0, fuse_addr}),
      .src_attached(src_att), .debug_acc_detected(dbg_det),
      .i2c_scl1_pin(scl1), .i2c_scl2_pin(scl2), .i2c_slave_addr(slave_addr),
      .cc_pres(cc), .orientation_addr_select_pin_i(strap),
      .orientation_addr_select_pin(orient), .int_n_pin(int_n),
      .debug_acc_detect_out(dbg_out), .sink_switch_en(sink_en),
      .source_switch_en(src_en), .general_io_one(gio1),
      .general_io_two(gio2));

   pcr_mgr_model i_pcr_mgr_model (.frame(frame), .use_two(use_two),
      .scl1(scl1), .scl2(scl2));

   // ******************************
   // clock, timeout, verdict
   // ******************************
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // ******************************
   // register bus tasks
   // ******************************
   // handshakes sampled half a cycle before the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] b);
      int   k;
      logic aw_r;
      logic w_r;
      logic b_r;
      k   = 0;
      b_r = 1'h0;
      @(posedge aclk);
      req.awvalid <= 1'h1;
      req.awaddr  <= a;
      req.wvalid  <= 1'h1;
      req.wdata   <= v;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'h1;
      do begin
         @(negedge aclk);
         k++;
         aw_r = rsp.awready & req.awvalid;
         w_r  = rsp.wready & req.wvalid;
         b_r  = rsp.bvalid;
         b    = rsp.bresp;
         @(posedge aclk);
         if (aw_r) req.awvalid <= 1'h0;
         if (w_r) req.wvalid <= 1'h0;
      end while (b_r !== 1'h1 && k < 100);
      req.bready <= 1'h0;
      if (b_r !== 1'h1) err_total++;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] b);
      int   k;
      logic ar_r;
      logic r_r;
      k   = 0;
      r_r = 1'h0;
      @(posedge aclk);
      req.arvalid <= 1'h1;
      req.araddr  <= a;
      req.rready  <= 1'h1;
      do begin
         @(negedge aclk);
         k++;
         ar_r = rsp.arready & req.arvalid;
         r_r  = rsp.rvalid;
         v    = rsp.rdata;
         b    = rsp.rresp;
         @(posedge aclk);
         if (ar_r) req.arvalid <= 1'h0;
      end while (r_r !== 1'h1 && k < 100);
      req.rready <= 1'h0;
      if (r_r !== 1'h1) err_total++;
   endtask : rd

   task automatic wait_stat(input int b);
      int k;
      k = 0;
      do begin
         rd(OFS_STATUS, d, r);
         k++;
      end while (d[b] !== 1'h1 && k < 200);
      `CHK(d[b], 1'h1)
   endtask : wait_stat

   // ******************************
   // test sequence
   // ******************************
   initial begin
      aresetn = 1'h0;
      req     = '0;
      vdd     = 1'h0;
      vbus    = 1'h0;
      src_att = 1'h0;
      dbg_det = 1'h0;
      frame   = 1'h0;
      use_two = 1'h0;
      strap   = 1'h1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (6) @(posedge aclk);
      `CHK(cc, 4'h3)
      `CHK(int_n.oe_n, 1'h1)
      vbus <= 1'h1;
      wait_stat(STAT_DEAD);
      `CHK(d[2:0], 3'h6)
      wait_stat(STAT_RUN);
      src_att <= 1'h1;
      repeat (3) @(posedge aclk);
      `CHK(sink_en, 1'h1)
      `CHK(cc, 4'h3)
      src_att <= 1'h0;
      repeat (3) @(posedge aclk);
      `CHK(sink_en, 1'h0)
      vdd <= 1'h1;
      wait_stat(STAT_VDD);
      `CHK(d[14:8], {I2C_ADDR_BASE, 2'h1})
      `CHK(orient.oe_n, 1'h0)
      `CHK(int_n, 2'h0)
      rd(OFS_IST, d, r);
      `CHK(d[3:0], 4'h7)
      rd(OFS_TRIM, d, r);
      `CHK(d, 32'hA3A2_A1A0)
      use_two <= 1'h1;
      frame   <= 1'h1;
      repeat (60) @(posedge aclk);
      frame <= 1'h0;
      repeat (6) @(posedge aclk);
      `CHK(slave_addr, {I2C_ADDR_BASE, 2'h3})
      wr(OFS_IST, 32'h0000_000F, r);
      repeat (2) @(posedge aclk);
      `CHK(int_n.oe_n, 1'h1)
      wr(OFS_IMASK, 32'h0000_0000, r);
      dbg_det <= 1'h1;
      repeat (4) @(posedge aclk);
      rd(OFS_IST, d, r);
      `CHK(d[IRQ_DEBUG], 1'h1)
      `CHK(int_n.oe_n, 1'h1)
      wr(OFS_IMASK, 32'h0000_000F, r);
      repeat (2) @(posedge aclk);
      `CHK(int_n.oe_n, 1'h0)
      wr(OFS_CTRL, 32'h0000_005C, r);
      repeat (3) @(posedge aclk);
      `CHK(sink_en, 1'h1)
      `CHK(src_en, 1'h1)
      `CHK({gio2, gio1, orient.out}, 3'h2)
      `CHK(dbg_out, 2'h0)
      dbg_det <= 1'h0;
      wr(OFS_IST, 32'h0000_000F, r);
      wr(OFS_CTRL, 32'h0000_005E, r);
      for (n = 0; n < 2200 && cc.cc1_rp_en !== 1'h1; n++) @(posedge aclk);
      `CHK(cc, 4'hC)
      wr(OFS_CTRL, 32'h0000_0001, r);
      `CHK(r, RESP_OKAY)
      repeat (2) @(posedge aclk);
      wait_stat(STAT_RUN);
      rd(OFS_CTRL, d, r);
      `CHK(d, 32'h0000_0010)
      rd(OFS_IMASK, d, r);
      `CHK(d[3:0], IMASK_RESET)
      rd(OFS_IST, d, r);
      `CHK(d[3:0], 4'h3)
      `CHK({cc, sink_en, src_en}, 6'h0C)
      rd(8'h20, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
      wr(8'h20, 32'h0000_0001, r);
      `CHK(r, RESP_SLVERR)
      report_and_stop();
   end
endmodule : tb
